//--- core/afd_map.vh
// Constants of the record-path FIR and decimation back end.
// Included by the FIR and path design files and the bench, not the FIFO; holds definitions only.
`ifndef AFD_MAP_VH
`define AFD_MAP_VH

// ************************************************************
// Coefficient page
// ************************************************************
`define AFD_COEF_BASE      7'h0E
`define AFD_COEF_LAST      7'h3F
`define AFD_COEF_NUM       25
`define AFD_COEF_FULL      16'h7FFF
`define AFD_COEF_ZERO      16'h0000
`define AFD_COEF_FULL_STEP 5

// ************************************************************
// Processing blocks, tap counts and variants
// ************************************************************
`define AFD_BLK_A_FIRST    5'h04
`define AFD_BLK_A_LAST     5'h06
`define AFD_BLK_B_FIRST    5'h0A
`define AFD_BLK_B_LAST     5'h0C
`define AFD_BLK_C_FIRST    5'h10
`define AFD_BLK_C_LAST     5'h12
`define AFD_BLK_25TAP_A    5'h06
`define AFD_BLK_20TAP_B    5'h0C
`define AFD_BLK_25TAP_C    5'h12
`define AFD_TAPS_20        5'h14
`define AFD_TAPS_25        5'h19
`define AFD_VAR_NONE       2'h0
`define AFD_VAR_A          2'h1
`define AFD_VAR_B          2'h2
`define AFD_VAR_C          2'h3

// ************************************************************
// Oversampling ratios, group delays in sample periods and CIC order
// ************************************************************
`define AFD_OSR_128        8'h80
`define AFD_OSR_64         8'h40
`define AFD_OSR_32         8'h20
`define AFD_GD_A           5'h11
`define AFD_GD_BC          5'h0B
`define AFD_CIC_ORDER      4

// ************************************************************
// Interface word lengths
// ************************************************************
`define AFD_WL_16          2'h0
`define AFD_WL_20          2'h1
`define AFD_WL_24          2'h2
`define AFD_WL_32          2'h3

`endif

//--- core/afd_fifo.v
// Word FIFO between the processing chain and the serial formatter.
// Assumes one clock; reader and writer handshake with valid and ready.
`timescale 1ns/1ps
module afd_fifo #(
  parameter W     = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire          core_clk_in,
  input  wire          nrst_in,
  input  wire          in_valid_in,
  output wire          in_ready_out,
  input  wire [W-1:0]  in_data_in,
  output wire          out_valid_out,
  input  wire          out_ready_in,
  output wire [W-1:0]  out_data_out
);
  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wptr_q;
  reg [AW-1:0] rptr_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  assign in_ready_out  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
  assign out_data_out  = mem[rptr_q];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  always @(posedge core_clk_in) begin
    if (push) begin
      mem[wptr_q] <= in_data_in;
    end
  end

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wptr_q <= {AW{1'b0}};
      rptr_q <= {AW{1'b0}};
      cnt_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_q <= (wptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= (rptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // afd_fifo

//--- core/afd_fir.v
// Serial multiply-accumulate FIR over up to 25 taps.
// Assumes a new sample arrives only while busy_out is low.
`timescale 1ns/1ps
`include "afd_map.vh"
module afd_fir #(
  parameter NT = 25
) (
  input  wire        core_clk_in,
  input  wire        nrst_in,
  input  wire        smp_valid_in,
  input  wire [15:0] smp_in,
  input  wire [4:0]  ntaps_in,
  output wire [4:0]  coef_idx_out,
  input  wire [15:0] coef_in,
  output reg         res_valid_out,
  output reg  [39:0] res_out,
  output wire        busy_out
);
  reg  [15:0] hist_q [0:NT-1];
  reg  [4:0]  idx_q;
  reg         busy_q;
  reg  [39:0] acc_q;
  wire [31:0] prod;
  wire [39:0] acc_d;
  genvar      g;

  assign coef_idx_out = idx_q;
  assign busy_out     = busy_q;
  assign prod  = $signed(hist_q[idx_q]) * $signed(coef_in);
  assign acc_d = acc_q + {{8{prod[31]}}, prod};

  generate
    for (g = 0; g < NT; g = g + 1) begin : g_hist
      always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          hist_q[g] <= 16'h0000;
        end else if (smp_valid_in && !busy_q) begin
          hist_q[g] <= (g == 0) ? smp_in : hist_q[(g == 0) ? 0 : g-1];
        end
      end
    end
  endgenerate

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idx_q         <= 5'h00;
      busy_q        <= 1'b0;
      acc_q         <= 40'h0000000000;
      res_valid_out <= 1'b0;
      res_out       <= 40'h0000000000;
    end else begin
      res_valid_out <= 1'b0;
      if (!busy_q && smp_valid_in) begin
        busy_q <= 1'b1;
        idx_q  <= 5'h00;
        acc_q  <= 40'h0000000000;
      end else if (busy_q) begin
        acc_q <= acc_d;
        idx_q <= idx_q + 5'h01;
        // A tap count lowered mid-run must still end the pass in range.
        if (idx_q >= ntaps_in - 5'h01) begin
          busy_q        <= 1'b0;
          res_valid_out <= 1'b1;
          res_out       <= acc_d;
        end
      end
    end
  end
endmodule // afd_fir

//--- core/afd_path.v
// Record-path back end: coefficient page, decimator, FIR, paired word hand-over.
// Assumes modulator words come from on-chip logic on core_clk_in, at least
// 32 clocks apart, and only while mod_ready_out is high.
//
// Overview of operation
// R1: FIR exists only in block_25tap_a, block_20tap_b and block_25tap_c.
// R2: FIR output sums coefficient n times input delayed n samples, n to 24 or 19.
// R3: Each coefficient is a 16-bit two's-complement value from two byte registers.
// R4: Host rewrites all used coefficients before using an FIR block.
// R5: Host zeroes registers 24,25,34,35,44,45,54,55 for an all-pass response.
// R6: Coefficient n sits at page registers 14+2n and 15+2n, n 0 to 24.
// R7: After reset coefficients 0,5,10,15,20 are full scale, others zero.
// R8: Decimator reduces oversampled rate by the ratio via CIC then linear-phase stages.
// R9: The decimation variant follows only from the selected processing block.
// R10: Variant A: up to 48 kHz at ratio 128 or 64, 96 kHz at 64, delay 17.
// R11: Host should use ratio 128 with variant A for best performance.
// R12: Variant B: up to 96 kHz at ratio 64, group delay 11 periods.
// R13: Variant C: ratio 32 for 192 ksps, passband 0.11 fs, delay 11 periods.
// R14: The chain delivers 32-bit words to the formatter once per sample period.
// R15: Each sample period hands over a left word and a right word.
// R16: Each word is rounded to the configured interface word length.
// R17: The same mono sample goes into both left and right words.
// R18: Coefficients are signed 1.15 fixed point, minus one to just below one.
// R19: Lower register of a pair holds the high byte, higher one the low byte.
`timescale 1ns/1ps
`include "afd_map.vh"
module afd_path #(
  parameter MOD_W      = 4,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input  wire             core_clk_in,
  input  wire             nrst_in,
  input  wire [6:0]       reg_addr_in,
  input  wire             reg_wr_in,
  input  wire [7:0]       reg_wdata_in,
  input  wire             reg_rd_in,
  output reg  [7:0]       reg_rdata_out,
  input  wire [4:0]       proc_block_in,
  input  wire [7:0]       adc_oversampling_ratio_in,
  input  wire [1:0]       word_len_in,
  input  wire             mod_valid_in,
  input  wire [MOD_W-1:0] mod_data_in,
  output reg              mod_ready_out,
  output reg              word_valid_out,
  output reg  [31:0]      word_data_out,
  output reg              word_right_out,
  input  wire             word_ready_in,
  output reg              cfg_ok_out,
  output reg              fir_active_out
);
  localparam ACC_W = MOD_W + 28;
  localparam NO    = `AFD_CIC_ORDER;
  localparam OS_IDLE  = 2'h0;
  localparam OS_LEFT  = 2'h1;
  localparam OS_RIGHT = 2'h2;

  // ************************************************************
  // Coefficient page
  // ************************************************************
  reg  [15:0] coef_q [0:`AFD_COEF_NUM-1];
  wire        coef_hit;
  wire [6:0]  coef_off;
  wire [4:0]  coef_sel;
  wire        coef_lsb;
  genvar      g;

  assign coef_hit = (reg_addr_in >= `AFD_COEF_BASE) && (reg_addr_in <= `AFD_COEF_LAST);
  assign coef_off = reg_addr_in - `AFD_COEF_BASE; // R6
  assign coef_sel = coef_off[5:1]; // R6
  assign coef_lsb = coef_off[0]; // R19

  generate
    for (g = 0; g < `AFD_COEF_NUM; g = g + 1) begin : g_coef
      always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          coef_q[g] <= (g % `AFD_COEF_FULL_STEP == 0) ? `AFD_COEF_FULL : `AFD_COEF_ZERO; // R7
        end else if (reg_wr_in && coef_hit && coef_sel == g) begin
          if (coef_lsb) begin
            coef_q[g][7:0] <= reg_wdata_in; // R19
          end else begin
            coef_q[g][15:8] <= reg_wdata_in; // R3
          end
        end
      end
    end
  endgenerate

  // Unmapped page addresses read as zero.
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      if (!coef_hit) begin
        reg_rdata_out <= 8'h00;
      end else if (coef_lsb) begin
        reg_rdata_out <= coef_q[coef_sel][7:0]; // R19
      end else begin
        reg_rdata_out <= coef_q[coef_sel][15:8];
      end
    end
  end

  // ************************************************************
  // Block decode
  // ************************************************************
  reg  [1:0] variant;
  reg        fir_en;
  reg  [4:0] ntaps;
  reg  [4:0] gd_len;
  reg        osr_ok;
  reg  [4:0] cic_sh;

  // There is no separate variant control; the block number alone decides.
  always @* begin
    fir_en = 1'b0;
    ntaps  = `AFD_TAPS_25;
    if (proc_block_in >= `AFD_BLK_A_FIRST && proc_block_in <= `AFD_BLK_A_LAST) begin
      variant = `AFD_VAR_A; // R9
    end else if (proc_block_in >= `AFD_BLK_B_FIRST && proc_block_in <= `AFD_BLK_B_LAST) begin
      variant = `AFD_VAR_B; // R9
    end else if (proc_block_in >= `AFD_BLK_C_FIRST && proc_block_in <= `AFD_BLK_C_LAST) begin
      variant = `AFD_VAR_C; // R9
    end else begin
      variant = `AFD_VAR_NONE;
    end
    case (proc_block_in)
      `AFD_BLK_25TAP_A: fir_en = 1'b1; // R1
      `AFD_BLK_25TAP_C: fir_en = 1'b1; // R1
      `AFD_BLK_20TAP_B: begin
        fir_en = 1'b1; // R1
        ntaps  = `AFD_TAPS_20; // R2
      end
      default: fir_en = 1'b0;
    endcase
  end

  always @* begin
    case (variant)
      `AFD_VAR_A: begin
        gd_len = `AFD_GD_A; // R10
        osr_ok = (adc_oversampling_ratio_in == `AFD_OSR_128) ||
                 (adc_oversampling_ratio_in == `AFD_OSR_64); // R10
      end
      `AFD_VAR_B: begin
        gd_len = `AFD_GD_BC; // R12
        osr_ok = (adc_oversampling_ratio_in == `AFD_OSR_64); // R12
      end
      `AFD_VAR_C: begin
        gd_len = `AFD_GD_BC; // R13
        osr_ok = (adc_oversampling_ratio_in == `AFD_OSR_32); // R13
      end
      default: begin
        gd_len = `AFD_GD_BC;
        osr_ok = 1'b0;
      end
    endcase
  end

  // The CIC gain is ratio to the fourth; the shift brings full scale to 16 bits.
  always @* begin
    case (adc_oversampling_ratio_in)
      `AFD_OSR_64: cic_sh = 5'd24 - (5'd16 - MOD_W[4:0]);
      `AFD_OSR_32: cic_sh = 5'd20 - (5'd16 - MOD_W[4:0]);
      default:     cic_sh = 5'd28 - (5'd16 - MOD_W[4:0]);
    endcase
  end

  // ************************************************************
  // CIC decimator
  // ************************************************************
  wire [ACC_W-1:0] integ_in [0:NO];
  reg  [ACC_W-1:0] integ_q  [0:NO-1];
  wire [ACC_W-1:0] comb_w   [0:NO];
  reg  [ACC_W-1:0] comb_z_q [0:NO-1];
  reg  [7:0]       dec_cnt_q;
  wire             dec_tick;
  wire [ACC_W-1:0] comb_sh;
  wire [15:0]      cic_smp;

  assign integ_in[0] = {{(ACC_W-MOD_W){mod_data_in[MOD_W-1]}}, mod_data_in};
  assign comb_w[0]   = integ_q[NO-1];
  assign dec_tick    = mod_valid_in && (dec_cnt_q == adc_oversampling_ratio_in - 8'h01); // R8

  generate
    for (g = 0; g < NO; g = g + 1) begin : g_cic
      assign integ_in[g+1] = integ_q[g];
      assign comb_w[g+1]   = comb_w[g] - comb_z_q[g]; // R8
      always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          integ_q[g]  <= {ACC_W{1'b0}};
          comb_z_q[g] <= {ACC_W{1'b0}};
        end else begin
          if (mod_valid_in) begin
            integ_q[g] <= integ_q[g] + integ_in[g]; // R8
          end
          if (dec_tick) begin
            comb_z_q[g] <= comb_w[g];
          end
        end
      end
    end
  endgenerate

  assign comb_sh = $signed(comb_w[NO]) >>> cic_sh;
  assign cic_smp = comb_sh[15:0];

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dec_cnt_q <= 8'h00;
    end else if (mod_valid_in) begin
      dec_cnt_q <= dec_tick ? 8'h00 : dec_cnt_q + 8'h01;
    end
  end

  // ************************************************************
  // Linear-phase stage delay alignment
  // ************************************************************
  // Modelled as a pure delay so that each variant shows its own group delay.
  reg  [15:0] gd_mem [0:31];
  reg  [4:0]  gd_wptr_q;
  reg         smp_valid_q;
  reg  [15:0] smp_q;
  integer     i;

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gd_wptr_q   <= 5'h00;
      smp_valid_q <= 1'b0;
      smp_q       <= 16'h0000;
      for (i = 0; i < 32; i = i + 1) begin
        gd_mem[i] <= 16'h0000;
      end
    end else begin
      smp_valid_q <= dec_tick;
      if (dec_tick) begin
        gd_mem[gd_wptr_q] <= cic_smp;
        gd_wptr_q         <= gd_wptr_q + 5'h01;
        smp_q             <= gd_mem[gd_wptr_q - gd_len]; // R10
      end
    end
  end

  // ************************************************************
  // FIR section
  // ************************************************************
  wire [4:0]  fir_idx;
  wire        fir_done;
  wire [39:0] fir_acc;
  wire        fir_busy;
  wire [31:0] fir_word;
  wire        fir_sat;

  afd_fir #(
    .NT (`AFD_COEF_NUM)
  ) u_fir (
    .core_clk_in   (core_clk_in),
    .nrst_in       (nrst_in),
    .smp_valid_in  (smp_valid_q & fir_en),
    .smp_in        (smp_q),
    .ntaps_in      (ntaps),
    .coef_idx_out  (fir_idx),
    .coef_in       (coef_q[fir_idx]),
    .res_valid_out (fir_done),
    .res_out       (fir_acc),
    .busy_out      (fir_busy)
  );

  // The accumulator is in 2.30 units after 1.15 products; saturate only past 32 bits, then shift bits 30:0 into 1.31.
  assign fir_sat  = (fir_acc[39:31] != {9{1'b0}}) && (fir_acc[39:31] != {9{1'b1}});
  assign fir_word = fir_sat ? (fir_acc[39] ? 32'h80000000 : 32'h7FFFFFFF)
                            : {fir_acc[30:0], 1'b0}; // R18

  // ************************************************************
  // Result hand-off into the FIFO
  // ************************************************************
  reg         pend_q;
  reg  [31:0] pend_data_q;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [31:0] fifo_out_data;
  reg         fifo_pop;

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_q         <= 1'b0;
      pend_data_q    <= 32'h00000000;
      mod_ready_out  <= 1'b0;
      cfg_ok_out     <= 1'b0;
      fir_active_out <= 1'b0;
    end else begin
      cfg_ok_out     <= osr_ok;
      fir_active_out <= fir_en & fir_busy;
      // A new word wins over the handshake that empties the holding stage.
      if (fir_en && fir_done) begin
        pend_q      <= 1'b1;
        pend_data_q <= fir_word; // R2
      end else if (!fir_en && smp_valid_q) begin
        pend_q      <= 1'b1;
        pend_data_q <= {smp_q, 16'h0000}; // R14
      end else if (fifo_in_ready) begin
        pend_q <= 1'b0;
      end
      mod_ready_out <= fifo_in_ready & ~pend_q;
    end
  end

  afd_fifo #(
    .W     (32),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (pend_q),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (pend_data_q),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_out_data)
  );

  // ************************************************************
  // Word rounding and left/right pairing
  // ************************************************************
  reg  [31:0] wl_mask;
  reg  [31:0] wl_half;
  wire [32:0] rnd_sum;
  wire [31:0] rnd_word;
  reg  [1:0]  os_q;

  always @* begin
    case (word_len_in)
      `AFD_WL_16: begin
        wl_mask = 32'hFFFF0000;
        wl_half = 32'h00008000;
      end
      `AFD_WL_20: begin
        wl_mask = 32'hFFFFF000;
        wl_half = 32'h00000800;
      end
      `AFD_WL_24: begin
        wl_mask = 32'hFFFFFF00;
        wl_half = 32'h00000080;
      end
      default: begin
        wl_mask = 32'hFFFFFFFF;
        wl_half = 32'h00000000;
      end
    endcase
  end

  // Rounding up can pass positive full scale, so it clips instead of wrapping.
  assign rnd_sum  = {fifo_out_data[31], fifo_out_data} + {1'b0, wl_half}; // R16
  assign rnd_word = (rnd_sum[32] != rnd_sum[31]) ? (32'h7FFFFFFF & wl_mask)
                                                 : (rnd_sum[31:0] & wl_mask); // R16

  always @* begin
    fifo_pop = 1'b0;
    case (os_q)
      OS_IDLE:  fifo_pop = fifo_out_valid;
      OS_RIGHT: fifo_pop = fifo_out_valid & word_ready_in;
      default:  fifo_pop = 1'b0;
    endcase
  end

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      os_q           <= OS_IDLE;
      word_valid_out <= 1'b0;
      word_data_out  <= 32'h00000000;
      word_right_out <= 1'b0;
    end else begin
      case (os_q)
        OS_IDLE: begin
          if (fifo_out_valid) begin
            word_valid_out <= 1'b1; // R14
            word_data_out  <= rnd_word;
            word_right_out <= 1'b0; // R15
            os_q           <= OS_LEFT;
          end
        end
        OS_LEFT: begin
          if (word_ready_in) begin
            word_right_out <= 1'b1; // R17
            os_q           <= OS_RIGHT; // R15
          end
        end
        OS_RIGHT: begin
          if (word_ready_in) begin
            word_right_out <= 1'b0;
            if (fifo_out_valid) begin
              word_data_out <= rnd_word;
              os_q          <= OS_LEFT;
            end else begin
              word_valid_out <= 1'b0;
              os_q           <= OS_IDLE;
            end
          end
        end
        default: begin
          word_valid_out <= 1'b0;
          os_q           <= OS_IDLE;
        end
      endcase
    end
  end
endmodule // afd_path

//--- verif/afd_path_monitor.sv
// Checker of the record-path back end, watching the ports of afd_path only.
// Assumes one clock and the asynchronous active-low reset of the block.
`timescale 1ns/1ps
module afd_path_monitor (
  input wire        core_clk_in,
  input wire        nrst_in,
  input wire [6:0]  reg_addr_in,
  input wire        reg_wr_in,
  input wire [7:0]  reg_wdata_in,
  input wire        reg_rd_in,
  input wire [7:0]  reg_rdata_out,
  input wire [4:0]  proc_block_in,
  input wire [7:0]  adc_oversampling_ratio_in,
  input wire        word_valid_out,
  input wire [31:0] word_data_out,
  input wire        word_right_out,
  input wire        word_ready_in,
  input wire        cfg_ok_out,
  input wire        fir_active_out
);
  // ************************************************************
  // Helpers and properties
  // ************************************************************
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  wire       mapped  = reg_addr_in >= 7'h0E && reg_addr_in <= 7'h3F;
  wire [4:0] blk     = proc_block_in;
  wire [7:0] osr     = adc_oversampling_ratio_in;
  wire       fir_blk = blk == 5'h06 || blk == 5'h0C || blk == 5'h12;
  wire       cfg_exp = (blk >= 5'h04 && blk <= 5'h06 && (osr == 8'h80 || osr == 8'h40))
                    || (blk >= 5'h0A && blk <= 5'h0C && osr == 8'h40)
                    || (blk >= 5'h10 && blk <= 5'h12 && osr == 8'h20);

  a_unmapped_read: assert property (reg_rd_in && !mapped |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_read_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  a_write_readback: assert property (reg_wr_in && mapped ##1 reg_rd_in && !reg_wr_in
    && $stable(reg_addr_in) |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("read after write lost the byte");
  a_cfg_flag: assert property (1'b1 |=> cfg_ok_out == $past(cfg_exp))
    else $error("configuration flag wrong");
  a_right_follows: assert property (word_valid_out && word_ready_in && !word_right_out
    |=> word_valid_out && word_right_out && word_data_out == $past(word_data_out))
    else $error("right word missing or differs");
  a_word_holds: assert property (word_valid_out && !word_ready_in
    |=> word_valid_out && $stable(word_data_out) && $stable(word_right_out))
    else $error("word changed while stalled");
  a_right_after_left: assert property ($rose(word_right_out)
    |-> $past(word_valid_out && word_ready_in && !word_right_out))
    else $error("right word without taken left");
  a_fir_bounded: assert property ($rose(fir_active_out)
    |-> fir_active_out [*8] ##[1:30] !fir_active_out)
    else $error("multiply-accumulate run length wrong");
  a_fir_bypass: assert property (!fir_blk && $stable(proc_block_in)
    |=> !$rose(fir_active_out))
    else $error("filter ran in a block without one");

  c_fir_run: cover property ($rose(fir_active_out));
  c_right_taken: cover property (word_valid_out && word_ready_in && word_right_out);
  c_stall: cover property (word_valid_out && !word_ready_in);
endmodule  // afd_path_monitor

bind afd_path afd_path_monitor afd_path_monitor_i (.core_clk_in, .nrst_in, .reg_addr_in,
  .reg_wr_in, .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .proc_block_in,
  .adc_oversampling_ratio_in, .word_valid_out, .word_data_out, .word_right_out,
  .word_ready_in, .cfg_ok_out, .fir_active_out);

//--- verif/afd_fmt_model.sv
// Stand-in for the serial formatter that takes the paired words.
// Same clock as the back end; mode 0 prompt, 1 slow, 2 holding off.
`timescale 1ns/1ps
module afd_fmt_model (
  input  wire       core_clk_in,
  input  wire       nrst_in,
  input  wire [1:0] mode_in,
  output reg        word_ready_out
);
  // ************************************************************
  // Acceptance pacing
  // ************************************************************
  reg [2:0] cnt_q;
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q          <= 3'h0;
      word_ready_out <= 1'b0;
    end else begin
      cnt_q          <= cnt_q + 3'h1;
      // Slow mode takes one word in eight clocks, so a full buffer drains under stall.
      word_ready_out <= mode_in == 2'h0 || (mode_in == 2'h1 && cnt_q == 3'h7);
    end
  end
endmodule  // afd_fmt_model

//--- verif/testbench.sv
// Self-checking bench of the record-path back end.
// Drives the register page, a DC modulator stream and a stalling formatter.
`timescale 1ns/1ps
`include "afd_map.vh"
module testbench;
  // ************************************************************
  // Stimulus, model and watchers
  // ************************************************************
  reg          core_clk_in = 1'b0;
  reg          nrst_in = 1'b0;
  reg  [6:0]   reg_addr_in = 7'h00;
  reg          reg_wr_in = 1'b0;
  reg  [7:0]   reg_wdata_in = 8'h00;
  reg          reg_rd_in = 1'b0;
  reg  [4:0]   proc_block_in = `AFD_BLK_25TAP_C;
  reg  [7:0]   adc_oversampling_ratio_in = `AFD_OSR_32;
  reg  [1:0]   word_len_in = `AFD_WL_32;
  reg          mod_valid_in = 1'b0;
  reg  [3:0]   mod_data_in = 4'h3;
  reg  [1:0]   mode = 2'h2;
  reg          feed = 1'b0;
  reg          rd_seen = 1'b0;
  reg  [4:0]   fcnt = 5'h00;
  reg  [15:0]  s = 16'h9533;
  reg  [31:0]  last_left = 32'h0;
  wire [7:0]   reg_rdata_out;
  wire [31:0]  word_data_out;
  wire         mod_ready_out, word_valid_out, word_right_out, word_ready_in;
  wire         cfg_ok_out, fir_active_out;
  int          bad_count = 0, check_count = 0, pairs = 0;
  logic [31:0] wq[$];
  logic [7:0]  rq[$];

  always #5 core_clk_in = ~core_clk_in;
  afd_path afd_path_i (.core_clk_in, .nrst_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in,
    .reg_rd_in, .reg_rdata_out, .proc_block_in, .adc_oversampling_ratio_in, .word_len_in,
    .mod_valid_in, .mod_data_in, .mod_ready_out, .word_valid_out, .word_data_out,
    .word_right_out, .word_ready_in, .cfg_ok_out, .fir_active_out);
  afd_fmt_model afd_fmt_model_i (.core_clk_in, .nrst_in, .mode_in(mode),
    .word_ready_out(word_ready_in));

  task chk(input [31:0] got, input [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic [15:0] lfsr(input [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task bus(input w, input r, input [6:0] a, input [7:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    if (r) rq.push_back(d);
  endtask
  // Waits n pairs so the CIC, delay line and taps settle on the DC input.
  task run(input [4:0] b, input [1:0] wl, input int n, input [31:0] e);
    int p0;
    @(posedge core_clk_in);
    proc_block_in <= b;
    word_len_in <= wl;
    p0 = pairs;
    while (pairs < p0 + n) @(posedge core_clk_in);
    wq.push_back(e);
    while (wq.size() != 0) @(posedge core_clk_in);
    chk(cfg_ok_out, b == `AFD_BLK_25TAP_C);
    $display("stream test on block %0d done", b);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    rd_seen <= reg_rd_in;
    fcnt <= fcnt + 5'h01;
    mod_valid_in <= feed && fcnt == 5'h1F && mod_ready_out;
    if (word_valid_out && word_ready_in) begin
      if (!word_right_out) begin
        last_left = word_data_out;
        pairs++;
        if (wq.size() != 0) chk(word_data_out, wq.pop_front());
      end else begin
        chk(word_data_out, last_left);
      end
    end
  end
  always @(negedge core_clk_in) if (rd_seen) chk(reg_rdata_out, rq.pop_front());

  initial begin
    repeat (99000) @(posedge core_clk_in);
    bad_count++;
    print_verdict;
  end

  initial begin
    int n;
    logic [15:0] c;
    repeat (3) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    for (n = 0; n < 25; n++) begin
      c = (n % 5 == 0) ? 16'h7FFF : 16'h0000;
      bus(0, 1, 7'(14 + 2 * n), c[15:8]);
      bus(0, 1, 7'(15 + 2 * n), c[7:0]);
    end
    bus(0, 1, 7'h0D, 8'h00);
    for (n = 14; n < 64; n++) begin
      s = lfsr(s);
      bus(1, 0, 7'(n), s[7:0]);
      bus(0, 1, 7'(n), s[7:0]);
    end
    bus(1, 0, 7'h0D, 8'hA5);
    bus(0, 1, 7'h0D, 8'h00);
    bus(0, 1, 7'h7F, 8'h00);
    for (n = 0; n < 25; n++) begin
      c = (n == 0) ? 16'h4000 : (n == 20) ? 16'h7FFF : 16'h0000;
      bus(1, 0, 7'(14 + 2 * n), c[15:8]);
      bus(1, 0, 7'(15 + 2 * n), c[7:0]);
    end
    bus(0, 1, 7'h36, 8'h7F);
    bus(0, 0, 7'h00, 8'h00);
    $display("register test done");
    // Formatter holds off first, so the first word stalls at the output.
    feed <= 1'b1;
    while (mod_ready_out !== 1'b0) @(posedge core_clk_in);
    mode <= 2'h1;
    run(`AFD_BLK_25TAP_C, `AFD_WL_32, 36, 32'h47FFA000);
    run(`AFD_BLK_25TAP_A, `AFD_WL_16, 3, 32'h48000000);
    mode <= 2'h0;
    run(`AFD_BLK_20TAP_B, `AFD_WL_20, 8, 32'h18000000);
    run(`AFD_BLK_A_FIRST, `AFD_WL_24, 20, 32'h30000000);
    feed <= 1'b0;
    adc_oversampling_ratio_in <= `AFD_OSR_128;
    repeat (2) @(posedge core_clk_in);
    chk(cfg_ok_out, 1'b1);
    nrst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    bus(0, 1, 7'h0E, 8'h7F);
    bus(0, 0, 7'h00, 8'h00);
    repeat (3) @(posedge core_clk_in);
    $display("reset restore test done");
    print_verdict;
  end
endmodule  // testbench
